// ### abs_regs.vh
// Register offsets, field positions, reset values and encodings of the bit-field/store execution unit
// ====================================================================
// How it works
// - Float to int nearest converts source two, single or double, to integer.
// - Unbiased source exponent of thirty or more raises conversion overflow, no result.
// - Reserved float encodings raise reserved operand exception.
// - Zero destination register or disabled FPU raises unimplemented exception.
// - Precision code 00 means single, 01 means double.
// - Register OR writes first OR second, optionally second complemented first.
// - Immediate OR hits low half, or high half with option; other half passes.
// - Rotate right by offset; register form uses five low bits of source two.
// - Set field ORs width ones at offset; width zero means 32; overflow dropped.
// - Register form takes width from bits 9-5, offset from bits 4-0.
// - Write address is base plus zero-extended literal or signed register index.
// - Scaled index multiplies by 1, 2, 4 or 8 per transfer size.
// - Size code 00 double, 01 word, 10 half, 11 byte.
// - Pair write makes two word transactions; top register pairs with zero register.
// - Bus is not locked between the two pair write transactions.
// - Space select follows privilege bit: supervisor when set, user when clear.
// - Forced user space option goes to user; outside supervisor it faults.
// - Misaligned write faults unless masked; bus fault gives data access exception.
// - Control register write copies general register; supervisor only, else fault.
// - Subtract writes first minus second or minus zero-extended literal.
// - Carry zero means borrow; borrow-in consumes carry, borrow-out stores it.
// - Subtract raises integer overflow when result not signed 32-bit.
// - Subtract adds inverted second operand plus one or carry over 32 bits.
`ifndef ABS_REGS_VH
`define ABS_REGS_VH
// ====================================================================
// Register byte offsets
`define ABS_CMD      8'h00
`define ABS_SRC1     8'h04
`define ABS_SRC2     8'h08
`define ABS_SRC2_HI  8'h0C
`define ABS_IMM      8'h10
`define ABS_DATA0    8'h14
`define ABS_DATA1    8'h18
`define ABS_PSW      8'h1C
`define ABS_GO       8'h20
`define ABS_RESULT   8'h24
`define ABS_STATUS   8'h28
// ====================================================================
// Command fields
`define ABS_OP_LSB   0
`define ABS_IMM_B    3
`define ABS_CMPL_B   4
`define ABS_HIGH_B   5
`define ABS_SCALE_B  6
`define ABS_USR_B    7
`define ABS_BIN_B    8
`define ABS_BOUT_B   9
`define ABS_SIZE_LSB 10
`define ABS_PREC_LSB 12
`define ABS_DEST_LSB 14
`define ABS_CTL_LSB  19
// Operations
`define ABS_OP_NINT  3'h0
`define ABS_OP_OR    3'h1
`define ABS_OP_ROT   3'h2
`define ABS_OP_SET   3'h3
`define ABS_OP_ST    3'h4
`define ABS_OP_STCR  3'h5
`define ABS_OP_SUB   3'h6
// Processor state word bits
`define ABS_PSW_MODE 0
`define ABS_PSW_CY   1
`define ABS_PSW_FPD  2
`define ABS_PSW_MXM  3
`define ABS_PSW_RST  4'h0
// Encodings
`define ABS_PREC_SGL 2'h0
`define ABS_PREC_DBL 2'h1
`define ABS_SZ_DBL   2'h0
`define ABS_SZ_WORD  2'h1
`define ABS_SZ_HALF  2'h2
`define ABS_SZ_BYTE  2'h3
`define ABS_OVF_EXP  12'sd30
`define ABS_SGL_BIAS 12'sd127
`define ABS_DBL_BIAS 12'sd1023
`define ABS_TOP_GPR  5'h1F
`endif

// ### abs_unit.v
// Bit-field, logical, subtract, float-to-int and store execution unit with APB registers
`timescale 1ns/10ps
`include "abs_regs.vh"
module abs_unit (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Data memory bus
    output reg         mem_req,
    output reg  [31:0] mem_addr,
    output reg  [3:0]  mem_be,
    output reg  [31:0] mem_wdata,
    output reg         space_select_signal,
    input  wire        mem_ack,
    input  wire        mem_fault,
    // Control register write port
    output reg         ctl_wr,
    output reg  [5:0]  ctl_sel,
    output reg  [31:0] ctl_data
);
// ====================================================================
// States
localparam [3:0] S_IDLE = 4'b0001;
localparam [3:0] S_MEM1 = 4'b0010;
localparam [3:0] S_GAP  = 4'b0100;
localparam [3:0] S_MEM2 = 4'b1000;

reg  [3:0]  state;
reg  [31:0] cmd;
reg  [31:0] src1;
reg  [31:0] src2;
reg  [31:0] src2_hi;
reg  [15:0] imm;
reg  [31:0] data0;
reg  [31:0] data1;
reg  [3:0]  psw;
reg  [31:0] result;
reg  [9:0]  stat;
reg  [31:0] second_word;

// ====================================================================
// Log2 of transfer size in bytes
function [1:0] size_log;
    input [1:0] code;
    begin
        case (code)
            `ABS_SZ_DBL:  size_log = 2'd3;
            `ABS_SZ_WORD: size_log = 2'd2;
            `ABS_SZ_HALF: size_log = 2'd1;
            default:      size_log = 2'd0;
        endcase
    end
endfunction

wire [2:0]  op      = cmd[`ABS_OP_LSB+2:`ABS_OP_LSB];
wire        imm_f   = cmd[`ABS_IMM_B];
wire [1:0]  size    = cmd[`ABS_SIZE_LSB+1:`ABS_SIZE_LSB];
wire [1:0]  prec    = cmd[`ABS_PREC_LSB+1:`ABS_PREC_LSB];
wire [4:0]  dest    = cmd[`ABS_DEST_LSB+4:`ABS_DEST_LSB];
wire        mode    = psw[`ABS_PSW_MODE];
wire        wr_acc  = psel & penable & pready & pwrite;
wire        go      = wr_acc & (paddr == `ABS_GO) & pwdata[0] & (state == S_IDLE);

// ====================================================================
// OR with complement or half-word literal
reg  [31:0] or_res;
always @* begin
    if (imm_f) begin
        if (cmd[`ABS_HIGH_B])
            or_res = src1 | {imm, 16'h0000};
        else
            or_res = src1 | {16'h0000, imm};
    end else begin
        or_res = src1 | (cmd[`ABS_CMPL_B] ? ~src2 : src2);
    end
end

// ====================================================================
// Rotate and set field; immediate form carries W5/O5 in the literal
wire [9:0]  fld  = imm_f ? imm[9:0] : src2[9:0];
wire [4:0]  offs = fld[4:0];
wire [4:0]  wid  = fld[9:5];
wire [63:0] rot2 = {src1, src1} >> offs;
wire [31:0] rot_res = rot2[31:0];
wire [32:0] ones = (wid == 5'd0) ? {1'b0, 32'hFFFF_FFFF} : ((33'h0_0000_0001 << wid) - 33'h0_0000_0001);
wire [63:0] ones_sh = {31'h0000_0000, ones} << offs;
wire [31:0] set_res = src1 | ones_sh[31:0];

// ====================================================================
// Subtract as add of inverse
// borrow in
wire        cin     = cmd[`ABS_BIN_B] ? psw[`ABS_PSW_CY] : 1'b1;
wire [31:0] sub_b   = imm_f ? {16'h0000, imm} : src2;
wire [32:0] sub_sum = {1'b0, src1} + {1'b0, ~sub_b} + {32'h0000_0000, cin};
wire [31:0] low_sum = {1'b0, src1[30:0]} + {1'b0, ~sub_b[30:0]} + {31'h0000_0000, cin};
wire        sub_ovf = sub_sum[32] ^ low_sum[31];

// ====================================================================
// Float to integer, round to nearest even
// precision decode
wire        dbl   = (prec == `ABS_PREC_DBL);
wire        f_sgn = dbl ? src2_hi[31] : src2[31];
wire [10:0] f_exp = dbl ? src2_hi[30:20] : {3'b000, src2[30:23]};
wire [51:0] f_frc = dbl ? {src2_hi[19:0], src2} : {src2[22:0], 29'h0000_0000};
wire        e_max = dbl ? (f_exp == 11'h7FF) : (f_exp[7:0] == 8'hFF);
wire signed [11:0] ue = $signed({1'b0, f_exp}) - (dbl ? `ABS_DBL_BIAS : `ABS_SGL_BIAS);
wire        f_resv = e_max | ((f_exp == 11'h000) & (f_frc != 52'h0));
wire        f_zero = (f_exp == 11'h000) & (f_frc == 52'h0);
wire        f_ovf  = !f_resv && !f_zero && (ue >= `ABS_OVF_EXP);
wire signed [12:0] sh_s = 13'sd52 - {ue[11], ue};
wire [6:0]  sh     = (sh_s > 13'sd127) ? 7'd127 : sh_s[6:0];
wire [105:0] fx    = {1'b1, f_frc, 53'h0} >> sh;
wire [31:0] f_int  = fx[84:53];
wire        f_g    = fx[52];
wire        f_st   = |fx[51:0];
wire [31:0] f_mag  = f_int + {31'h0000_0000, f_g & (f_st | f_int[0])};
wire [31:0] f_res  = f_zero ? 32'h0000_0000 : (f_sgn ? (~f_mag + 32'h0000_0001) : f_mag);
wire        f_unimp = (dest == 5'd0) | psw[`ABS_PSW_FPD];

// ====================================================================
// Store address, lanes and checks
// scale by size
wire [31:0] idx   = cmd[`ABS_SCALE_B] ? (src2 << size_log(size)) : src2;
wire [31:0] st_a  = src1 + (imm_f ? {16'h0000, imm} : idx);
wire [2:0]  amask = (size == `ABS_SZ_DBL) ? 3'h7 : {1'b0, size_log(size)};
wire        mis   = ((st_a[2:0] & ((3'h1 << size_log(size)) - 3'h1)) != 3'h0) & (amask != 3'h0);
wire        usr_f = cmd[`ABS_USR_B];
wire        st_pv = usr_f & ~mode;
wire        st_ma = mis & ~psw[`ABS_PSW_MXM];
reg  [3:0]  be;
reg  [31:0] wd;
always @* begin
    case (size)
        `ABS_SZ_BYTE: begin
            be = 4'h1 << st_a[1:0];
            wd = {4{data0[7:0]}};
        end
        `ABS_SZ_HALF: begin
            be = st_a[1] ? 4'hC : 4'h3;
            wd = {2{data0[15:0]}};
        end
        default: begin
            be = 4'hF;
            wd = data0;
        end
    endcase
end

// ====================================================================
// Execution and memory sequencing
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= S_IDLE;
        result <= 32'h0000_0000;
        stat <= 10'h000;
        mem_req <= 1'b0;
        mem_addr <= 32'h0000_0000;
        mem_be <= 4'h0;
        mem_wdata <= 32'h0000_0000;
        space_select_signal <= 1'b0;
        second_word <= 32'h0000_0000;
        ctl_wr <= 1'b0;
        ctl_sel <= 6'h00;
        ctl_data <= 32'h0000_0000;
    end else begin
        ctl_wr <= 1'b0;
        stat[1] <= 1'b0;
        case (state)
            S_IDLE: begin
                if (go) begin
                    stat <= 10'h000;
                    case (op)
                        `ABS_OP_NINT: begin
                            if (f_unimp)
                                stat[5] <= 1'b1;
                            else if (f_resv)
                                stat[4] <= 1'b1;
                            else if (f_ovf)
                                stat[3] <= 1'b1;
                            else begin
                                result <= f_res;
                                stat[2] <= 1'b1;
                            end
                            stat[1] <= 1'b1;
                        end
                        `ABS_OP_OR: begin
                            result <= or_res;
                            stat[2:1] <= 2'b11;
                        end
                        `ABS_OP_ROT: begin
                            result <= rot_res;
                            stat[2:1] <= 2'b11;
                        end
                        `ABS_OP_SET: begin
                            result <= set_res;
                            stat[2:1] <= 2'b11;
                        end
                        `ABS_OP_SUB: begin
                            result <= sub_sum[31:0];
                            stat[9] <= sub_ovf;
                            stat[2] <= ~sub_ovf;
                            stat[1] <= 1'b1;
                        end
                        `ABS_OP_STCR: begin
                            if (mode) begin
                                ctl_wr <= 1'b1;
                                ctl_sel <= cmd[`ABS_CTL_LSB+5:`ABS_CTL_LSB];
                                ctl_data <= src1;
                            end else
                                stat[8] <= 1'b1;
                            stat[1] <= 1'b1;
                        end
                        `ABS_OP_ST: begin
                            if (st_pv) begin
                                stat[8] <= 1'b1;
                                stat[1] <= 1'b1;
                            end else if (st_ma) begin
                                stat[6] <= 1'b1;
                                stat[1] <= 1'b1;
                            end else begin
                                mem_req <= 1'b1;
                                mem_addr <= (size == `ABS_SZ_DBL) ? {st_a[31:2], 2'b00} : st_a;
                                mem_be <= be;
                                mem_wdata <= wd;
                                space_select_signal <= mode & ~usr_f;
                                second_word <= (dest == `ABS_TOP_GPR) ? 32'h0000_0000 : data1;
                                stat[0] <= 1'b1;
                                state <= S_MEM1;
                            end
                        end
                        default: begin
                            stat[1] <= 1'b1;
                        end
                    endcase
                end
            end
            S_MEM1, S_MEM2: begin
                if (mem_ack) begin
                    mem_req <= 1'b0;
                    if (mem_fault) begin
                        stat[7] <= 1'b1;
                        stat[1:0] <= 2'b10;
                        state <= S_IDLE;
                    end else if (state == S_MEM1 && size == `ABS_SZ_DBL) begin
                        state <= S_GAP;
                    end else begin
                        stat[1:0] <= 2'b10;
                        state <= S_IDLE;
                    end
                end
            end
            S_GAP: begin
                mem_req <= 1'b1;
                mem_addr <= mem_addr + 32'h0000_0004;
                mem_wdata <= second_word;
                state <= S_MEM2;
            end
            default: begin
                state <= S_IDLE;
            end
        endcase
    end
end

// ====================================================================
// APB register file; answers in the first access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cmd <= 32'h0000_0000;
        src1 <= 32'h0000_0000;
        src2 <= 32'h0000_0000;
        src2_hi <= 32'h0000_0000;
        imm <= 16'h0000;
        data0 <= 32'h0000_0000;
        data1 <= 32'h0000_0000;
        psw <= `ABS_PSW_RST;
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel & ~penable;
        if (psel & ~penable) begin
            pslverr <= 1'b0;
            case (paddr)
                `ABS_CMD:     prdata <= cmd;
                `ABS_SRC1:    prdata <= src1;
                `ABS_SRC2:    prdata <= src2;
                `ABS_SRC2_HI: prdata <= src2_hi;
                `ABS_IMM:     prdata <= {16'h0000, imm};
                `ABS_DATA0:   prdata <= data0;
                `ABS_DATA1:   prdata <= data1;
                `ABS_PSW:     prdata <= {28'h000_0000, psw};
                `ABS_GO:      prdata <= 32'h0000_0000;
                `ABS_RESULT:  prdata <= result;
                `ABS_STATUS:  prdata <= {22'h00_0000, stat};
                default: begin
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end
        // Operand writes while busy would corrupt a pair write
        if (wr_acc && state == S_IDLE) begin
            case (paddr)
                `ABS_CMD:     cmd <= pwdata;
                `ABS_SRC1:    src1 <= pwdata;
                `ABS_SRC2:    src2 <= pwdata;
                `ABS_SRC2_HI: src2_hi <= pwdata;
                `ABS_IMM:     imm <= pwdata[15:0];
                `ABS_DATA0:   data0 <= pwdata;
                `ABS_DATA1:   data1 <= pwdata;
                `ABS_PSW:     psw <= pwdata[3:0];
                default: begin
                end
            endcase
        end
        if (go && op == `ABS_OP_SUB && cmd[`ABS_BOUT_B])
            psw[`ABS_PSW_CY] <= sub_sum[32];
    end
end

endmodule // abs_unit

// ### abs_sva.sv
// Assertion checker on the unit's APB and memory bus ports
`timescale 1ns/10ps
module abs_sva (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pready,
    // Memory bus
    input wire        mem_req,
    input wire [31:0] mem_addr,
    input wire [3:0]  mem_be,
    input wire [31:0] mem_wdata,
    input wire        space_select_signal,
    input wire        mem_ack,
    input wire        mem_fault,
    // Control register port
    input wire        ctl_wr,
    input wire [5:0]  ctl_sel
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====================================================================
    // APB ready, memory write and control write steps
    sequence s_word_ok; mem_req && mem_ack && !mem_fault; endsequence
    sequence s_regrant; !mem_req ##1 mem_req; endsequence
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable({mem_addr, mem_be, mem_wdata, space_select_signal});
    endproperty
    property p_drop; mem_req && mem_ack |=> !mem_req; endproperty
    property p_pair; s_word_ok ##1 s_regrant |-> mem_addr == $past(mem_addr, 2) + 32'h4; endproperty
    property p_lane; mem_req |-> mem_be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF}; endproperty
    property p_byte; mem_req && $onehot(mem_be) |-> mem_be == (4'h1 << mem_addr[1:0]); endproperty
    property p_half; mem_req && (mem_be == 4'h3 || mem_be == 4'hC) |-> mem_addr[1] == mem_be[2]; endproperty
    property p_ctl; ctl_wr |=> !ctl_wr && $stable(ctl_sel); endproperty
    a_rdy: assert property (p_rdy) else $error("pready not one cycle");
    a_hold: assert property (p_hold) else $error("request changed before ack");
    a_drop: assert property (p_drop) else $error("bus kept after ack");
    a_pair: assert property (p_pair) else $error("second word not at next word");
    a_lane: assert property (p_lane) else $error("illegal byte enables");
    a_byte: assert property (p_byte) else $error("byte lane off address");
    a_half: assert property (p_half) else $error("half lane off address");
    a_ctl: assert property (p_ctl) else $error("control write not one cycle");
endmodule // abs_sva

bind abs_unit abs_sva i_abs_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .space_select_signal(space_select_signal), .mem_ack(mem_ack), .mem_fault(mem_fault),
    .ctl_wr(ctl_wr), .ctl_sel(ctl_sel)
);

// ### abs_mem.sv
// Data memory model: acks after a set delay, logs writes
`timescale 1ns/10ps
module abs_mem (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // Behaviour set by the bench
    input wire [3:0]  delay,
    input wire        fault,
    // Memory bus
    input wire        mem_req,
    input wire [31:0] mem_addr,
    input wire [3:0]  mem_be,
    input wire [31:0] mem_wdata,
    input wire        space_select_signal,
    output reg        mem_ack,
    output reg        mem_fault
);
    reg [68:0] log [0:15];
    reg [4:0]  log_n;
    reg [3:0]  wait_n;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            mem_fault <= 1'b0;
            log_n     <= 5'h0;
            wait_n    <= 4'h0;
        end else begin
            mem_ack   <= 1'b0;
            // Fault means nothing without ack, so it wanders
            mem_fault <= ~mem_fault;
            if (mem_req && !mem_ack) begin
                if (wait_n == delay) begin
                    mem_ack         <= 1'b1;
                    mem_fault       <= fault;
                    wait_n          <= 4'h0;
                    log[log_n[3:0]] <= {space_select_signal, mem_be, mem_addr, mem_wdata};
                    log_n           <= log_n + 5'h1;
                end else begin
                    wait_n <= wait_n + 4'h1;
                end
            end
        end
    end
endmodule // abs_mem

// ### tb.sv
// Self-checking bench: unit operations issued over APB
`timescale 1ns/10ps
`include "abs_regs.vh"
module tb;
    // ====================================================================
    // Signals
    reg         pclk;
    reg         presetn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata;
    reg  [3:0]  delay;
    reg         fault;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        mem_req;
    wire [31:0] mem_addr;
    wire [3:0]  mem_be;
    wire [31:0] mem_wdata;
    wire        space_select_signal;
    wire        mem_ack;
    wire        mem_fault;
    wire        ctl_wr;
    wire [5:0]  ctl_sel;
    wire [31:0] ctl_data;
    reg  [31:0] q;
    reg         err;
    integer     bad_count;
    integer     checks;
    integer     mcnt;
    integer     ctl_n;
    localparam [6:0] F_IMM = 7'h01, F_CMPL = 7'h02, F_HIGH = 7'h04, F_SCL = 7'h08;
    localparam [6:0] F_USR = 7'h10, F_BIN = 7'h20, F_BOUT = 7'h40;
    localparam [31:0] D0 = 32'hCAFE_F00D;
    abs_unit i_abs_unit (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .space_select_signal(space_select_signal),
        .mem_ack(mem_ack), .mem_fault(mem_fault), .ctl_wr(ctl_wr), .ctl_sel(ctl_sel), .ctl_data(ctl_data)
    );
    abs_mem i_abs_mem (
        .pclk(pclk), .presetn(presetn), .delay(delay), .fault(fault), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_be(mem_be), .mem_wdata(mem_wdata), .space_select_signal(space_select_signal),
        .mem_ack(mem_ack), .mem_fault(mem_fault)
    );
    always @(posedge pclk) begin
        if (ctl_wr === 1'b1) begin
            ctl_n <= ctl_n + 1;
        end
    end
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Run needs about 700 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count = bad_count + 1;
        test_done;
    end
    // ====================================================================
    // Tasks
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task chk(input [63:0] name, input [71:0] seen, input [71:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    // Holds the request until pready, then idles
    task xfer(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            chk("pready", pready, 72'h1);
            q = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    function [31:0] mk(input [2:0] o, input [6:0] f, input [1:0] sz, input [4:0] d);
        mk = {13'h0, d, 2'b00, sz, f, o};
    endfunction
    task run(input [31:0] cmd, s1, s2, imm);
        integer n;
        begin
            xfer(1'b1, `ABS_CMD, cmd);
            xfer(1'b1, `ABS_SRC1, s1);
            xfer(1'b1, `ABS_SRC2, s2);
            xfer(1'b1, `ABS_IMM, imm);
            xfer(1'b1, `ABS_GO, 32'h1);
            n = 0;
            xfer(1'b0, `ABS_STATUS, 0);
            while (q[0] !== 1'b0 && n < 40) begin
                n = n + 1;
                xfer(1'b0, `ABS_STATUS, 0);
            end
        end
    endtask
    task alu(input [31:0] cmd, s1, s2, imm, res, input [7:0] st);
        begin
            run(cmd, s1, s2, imm);
            chk("status", q[9:2], st);
            if (st[0] | st[7]) begin
                xfer(1'b0, `ABS_RESULT, 0);
                chk("result", q, res);
            end
        end
    endtask
    task sto(input [31:0] cmd, s1, s2, imm, input [7:0] st, input integer k);
        begin
            run(cmd, s1, s2, imm);
            chk("status", q[9:3], st[7:1]);
            chk("count", i_abs_mem.log_n, mcnt + k);
        end
    endtask
    task mw(input sp, input [3:0] be, input [31:0] a, input [31:0] d);
        begin
            chk("memwrite", i_abs_mem.log[mcnt], {sp, be, a, d});
            mcnt = mcnt + 1;
        end
    endtask
    // ====================================================================
    // Tests
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, delay, fault} = 0;
        {bad_count, checks, mcnt, ctl_n} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 8'h2C, 32'h1);
        chk("slverr", {err, q}, {1'b1, 32'h0});
        xfer(1'b1, `ABS_DATA0, D0);
        xfer(1'b1, `ABS_DATA1, 32'h1234_5678);
        xfer(1'b1, `ABS_PSW, 32'h1);
        alu(mk(1, 0, 0, 1), 32'h1234_0000, 32'h0000_00F0, 0, 32'h1234_00F0, 8'h01);
        alu(mk(1, F_CMPL, 0, 1), 32'h0100_0000, 32'hFFFF_0000, 0, 32'h0100_FFFF, 8'h01);
        alu(mk(1, F_IMM, 0, 1), 32'hAAAA_000F, 0, 32'h0000_5550, 32'hAAAA_555F, 8'h01);
        alu(mk(1, F_IMM | F_HIGH, 0, 1), 32'h0001_1234, 0, 32'h0000_8000, 32'h8001_1234, 8'h01);
        alu(mk(2, 0, 0, 1), 32'h0000_0001, 32'hFFFF_FFE4, 0, 32'h1000_0000, 8'h01);
        alu(mk(2, F_IMM, 0, 1), 32'h0000_0003, 0, 32'h0000_0001, 32'h8000_0001, 8'h01);
        alu(mk(3, 0, 0, 1), 32'h0000_0001, 32'h0000_00B0, 0, 32'h001F_0001, 8'h01);
        alu(mk(3, F_IMM, 0, 1), 32'h0000_0001, 0, 32'h0000_0004, 32'hFFFF_FFF1, 8'h01);
        alu(mk(3, 0, 0, 1), 0, 32'h0000_011C, 0, 32'hF000_0000, 8'h01);
        alu(mk(6, F_IMM | F_BIN | F_BOUT, 0, 1), 10, 0, 3, 6, 8'h01);
        xfer(1'b0, `ABS_PSW, 0);
        chk("carry", q[1], 1'b1);
        alu(mk(6, F_BOUT, 0, 1), 0, 1, 0, 32'hFFFF_FFFF, 8'h01);
        xfer(1'b0, `ABS_PSW, 0);
        chk("carry", q[1], 1'b0);
        alu(mk(6, 0, 0, 1), 32'h8000_0000, 1, 0, 32'h7FFF_FFFF, 8'h80);
        alu(mk(0, 0, 0, 1), 0, 32'h4020_0000, 0, 2, 8'h01);
        xfer(1'b1, `ABS_SRC2_HI, 32'h3FF8_0000);
        alu(mk(0, 0, 0, 1) | 32'h0000_1000, 0, 0, 0, 2, 8'h01);
        alu(mk(0, 0, 0, 1), 0, 32'h4E80_0000, 0, 0, 8'h02);
        alu(mk(0, 0, 0, 1), 0, 32'h7FC0_0000, 0, 0, 8'h04);
        alu(mk(0, 0, 0, 0), 0, 32'h4020_0000, 0, 0, 8'h08);
        sto(mk(4, F_IMM, 1, 1), 32'h0000_0100, 0, 32'h0000_0020, 8'h00, 1);
        mw(1'b1, 4'hF, 32'h0000_0120, D0);
        sto(mk(4, 0, 3, 1), 32'h0000_0200, 3, 0, 8'h00, 1);
        mw(1'b1, 4'h8, 32'h0000_0203, 32'h0D0D_0D0D);
        sto(mk(4, F_SCL, 2, 1), 32'h0000_0300, 32'hFFFF_FFFF, 0, 8'h00, 1);
        mw(1'b1, 4'hC, 32'h0000_02FE, 32'hF00D_F00D);
        sto(mk(4, F_SCL, 1, 1), 32'h0000_0300, 2, 0, 8'h00, 1);
        mw(1'b1, 4'hF, 32'h0000_0308, D0);
        delay <= 4'h3;
        sto(mk(4, F_SCL, 0, 31), 32'h0000_0400, 1, 0, 8'h00, 2);
        mw(1'b1, 4'hF, 32'h0000_0408, D0);
        mw(1'b1, 4'hF, 32'h0000_040C, 0);
        sto(mk(4, F_IMM, 0, 4), 32'h0000_0400, 0, 32'h0000_0018, 8'h00, 2);
        mw(1'b1, 4'hF, 32'h0000_0418, D0);
        mw(1'b1, 4'hF, 32'h0000_041C, 32'h1234_5678);
        fault <= 1'b1;
        sto(mk(4, 0, 0, 5), 32'h0000_0400, 32'h0000_0010, 0, 8'h20, 1);
        mw(1'b1, 4'hF, 32'h0000_0410, D0);
        fault <= 1'b0;
        delay <= 4'h0;
        sto(mk(4, F_USR, 1, 1), 32'h0000_0500, 0, 0, 8'h00, 1);
        mw(1'b0, 4'hF, 32'h0000_0500, D0);
        sto(mk(4, 0, 1, 1), 32'h0000_0502, 0, 0, 8'h10, 0);
        xfer(1'b1, `ABS_PSW, 32'h9);
        sto(mk(4, 0, 1, 1), 32'h0000_0502, 0, 0, 8'h00, 1);
        mw(1'b1, 4'hF, 32'h0000_0502, D0);
        sto(mk(5, 0, 0, 1) | 32'h0028_0000, 32'h89AB_CDEF, 0, 0, 8'h00, 0);
        chk("ctlport", {ctl_n, ctl_sel, ctl_data}, {32'd1, 6'h05, 32'h89AB_CDEF});
        xfer(1'b1, `ABS_PSW, 32'h4);
        sto(mk(4, 0, 1, 1), 32'h0000_0600, 0, 0, 8'h00, 1);
        mw(1'b0, 4'hF, 32'h0000_0600, D0);
        sto(mk(4, F_USR, 1, 1), 32'h0000_0600, 0, 0, 8'h40, 0);
        sto(mk(5, 0, 0, 1), 32'h0000_0001, 0, 0, 8'h40, 0);
        chk("ctlcount", ctl_n, 1);
        alu(mk(0, 0, 0, 1), 0, 32'h4020_0000, 0, 0, 8'h08);
        test_done;
    end
endmodule // tb
